// ===== dv/p3rcm_board.sv
// Board-side model of the reset pin and the two port 3 pins.
// Assumes the device's port 3 drive, enable and pull-up outputs change on the same clock.
module p3rcm_board (
    input wire logic clock_in,              // CPU clock
    input wire logic [1:0] port3_drv_in,    // Device drive levels
    input wire logic [1:0] port3_oe_in,     // Device output enables
    input wire logic [1:0] port3_pullup_in, // Device pull-up enables
    output logic port1_bit5_out,            // Reset pin level, pulled up on the board
    output logic [1:0] port3_pin_out        // Resolved port 3 pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rst_level = 1'b1;
    logic [1:0] ext_en = 2'h0;
    logic [1:0] ext_level = 2'h0;
    logic flip = 1'b0;

    // A floating pin without pull-up changes every cycle, so a stale value can never pass as a read.
    always @(posedge clock_in) begin
        flip <= ~flip;
    end

    assign port1_bit5_out = rst_level;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            port3_pin_out[i] = port3_oe_in[i] ? port3_drv_in[i] :
                               ext_en[i] ? ext_level[i] : (port3_pullup_in[i] | flip);
        end
    end

    task automatic drive_port3(input logic [1:0] en, input logic [1:0] lvl);
        @(posedge clock_in);
        ext_en <= en;
        ext_level <= lvl;
    endtask

    task automatic set_reset(input logic lvl);
        @(posedge clock_in);
        rst_level <= lvl;
    endtask

    task automatic pulse_reset(input int n);
        repeat (n) begin
            @(posedge clock_in);
            rst_level <= 1'b0;
            repeat (4) @(posedge clock_in);
            rst_level <= 1'b1;
            repeat (4) @(posedge clock_in);
        end
    endtask
endmodule

// ===== dv/test_port3_reset_pin_clockout_mux.sv
// Self-checking bench for the port 3, reset pin and clock output multiplexer.
// Assumes a zero-wait AHB-Lite slave whose hreadyout is fed back as hready.
module test_port3_reset_pin_clockout_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in, rst_in, power_on_in, user_config_byte1_in, rtc_xtal_in;
    logic [1:0] clk_src_in;
    logic hsel, hwrite;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, pin_b5, osc_out_sel, osc_in_sel, sync_b5, dev_rst, in_system_prog_mode;
    wire logic [1:0] pins, drv, oe, pull;
    wire logic [15:0] vec;
    int fail_count, cmp_count;
    logic prev;
    logic [2:0] size_sel;

    assign hready = hreadyout;
    always #20 clock_in = ~clock_in;

    p3rcm_mux dut_u (.clock_in(clock_in), .rst_in(rst_in), .power_on_in(power_on_in),
        .user_config_byte1_in(user_config_byte1_in), .clk_src_in(clk_src_in), .rtc_xtal_in(rtc_xtal_in),
        .port1_bit5_in(pin_b5), .port3_in(pins), .port3_out(drv), .port3_oe_out(oe),
        .port3_pullup_out(pull), .osc_output_sel_out(osc_out_sel), .osc_input_sel_out(osc_in_sel),
        .port1_bit5_out(sync_b5), .device_reset_out(dev_rst), .reset_vector_out(vec),
        .in_system_prog_mode_out(in_system_prog_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));

    p3rcm_board board_u (.clock_in(clock_in), .port3_drv_in(drv), .port3_oe_in(oe),
        .port3_pullup_in(pull), .port1_bit5_out(pin_b5), .port3_pin_out(pins));

    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // Only the watchdog ends a wait that never sees the slave ready.
    task automatic wait_ready();
        do begin
            @(posedge clock_in);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock_in);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= p3rcm_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= size_sel;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h00000000, x);
        chk_reg(what, exp, x);
    endtask

    task automatic set_in(input logic pwr, input logic cfg, input logic [1:0] src, input logic rtc);
        @(posedge clock_in);
        power_on_in <= pwr;
        user_config_byte1_in <= cfg;
        clk_src_in <= src;
        rtc_xtal_in <= rtc;
    endtask

    initial begin
        #400000;
        fail_count++;
        close_out();
    end

    initial begin
        clock_in = 1'b0;
        rst_in = 1'b1;
        power_on_in = 1'b0;
        user_config_byte1_in = 1'b0;
        clk_src_in = p3rcm_pkg::CLKSRC_INT_RC;
        rtc_xtal_in = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = p3rcm_pkg::HSIZE_WORD;
        size_sel = p3rcm_pkg::HSIZE_WORD;
        hwdata = 32'h00000000;
        fail_count = 0;
        cmp_count = 0;
        tick(7);
        chk_pin("oe in reset", 16'h0000, {14'h0000, oe});
        chk_pin("pullup in reset", 16'h0000, {14'h0000, pull});
        @(posedge clock_in);
        rst_in <= 1'b0;
        rd_chk("mode reset", p3rcm_pkg::OFS_PORT3_MODE, {28'h0000000, p3rcm_pkg::PORT3_MODE_RESET});
        rd_chk("latch reset", p3rcm_pkg::OFS_PORT3_LATCH, {30'h00000000, p3rcm_pkg::PORT3_LATCH_RESET});
        rd_chk("trim reset", p3rcm_pkg::OFS_OSC_TRIM, {24'h000000, p3rcm_pkg::OSC_TRIM_RESET});
        // A byte-sized write is refused, so the trim word must keep its reset value.
        size_sel = 3'h0;
        wr(p3rcm_pkg::OFS_OSC_TRIM, 32'h00000040);
        size_sel = p3rcm_pkg::HSIZE_WORD;
        rd_chk("trim byte write", p3rcm_pkg::OFS_OSC_TRIM, {24'h000000, p3rcm_pkg::OSC_TRIM_RESET});
        rd_chk("unmapped", 8'h20, 32'h00000000);
        chk_pin("resp", 16'h0000, {15'h0000, hresp});
        wr(p3rcm_pkg::OFS_STATUS, 32'hFFFFFFFF);
        rd_chk("status", p3rcm_pkg::OFS_STATUS, 32'h00000000);
        board_u.drive_port3(2'h3, 2'h2);
        tick(3);
        rd_chk("pin level", p3rcm_pkg::OFS_PIN_LEVEL, 32'h00000006);
        set_in(1'b1, 1'b0, p3rcm_pkg::CLKSRC_INT_RC, 1'b0);
        board_u.pulse_reset(2);
        tick(4);
        chk_pin("isp early", 16'h0000, {15'h0000, in_system_prog_mode});
        board_u.pulse_reset(1);
        tick(4);
        chk_pin("isp", 16'h0001, {15'h0000, in_system_prog_mode});
        set_in(1'b0, 1'b0, p3rcm_pkg::CLKSRC_INT_RC, 1'b0);
        board_u.drive_port3(2'h2, 2'h0);
        for (int m = 0; m < 4; m++) begin
            wr(p3rcm_pkg::OFS_PORT3_MODE, {28'h0000000, p3rcm_pkg::MODE_INPUT_ONLY, 2'(m)});
            tick(2);
            chk_pin("mode oe", {15'h0000, m == 1}, {14'h0000, oe});
            chk_pin("mode drive", {15'h0000, m == 1}, {15'h0000, drv[0]});
        end
        wr(p3rcm_pkg::OFS_PORT3_MODE, {28'h0000000, p3rcm_pkg::MODE_PUSH_PULL, p3rcm_pkg::MODE_PUSH_PULL});
        wr(p3rcm_pkg::OFS_PORT3_LATCH, 32'h00000002);
        tick(2);
        chk_pin("pp oe", 16'h0003, {14'h0000, oe});
        chk_pin("pp drive", 16'h0002, {14'h0000, drv});
        wr(p3rcm_pkg::OFS_PORT3_MODE, 32'h0000000A);
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 2; r++) begin
                set_in(1'b0, 1'b0, 2'(s), 1'(r));
                tick(1);
                chk_pin("osc out sel", {15'h0000, s == 3 || r == 1}, {15'h0000, osc_out_sel});
                chk_pin("osc in sel", {15'h0000, !(s < 2 && r == 0)}, {15'h0000, osc_in_sel});
            end
        end
        set_in(1'b0, 1'b0, p3rcm_pkg::CLKSRC_INT_RC, 1'b0);
        wr(p3rcm_pkg::OFS_OSC_TRIM, 32'h00000040);
        tick(2);
        chk_pin("clock_out_pin oe", 16'h0001, {15'h0000, oe[0]});
        prev = drv[0];
        for (int i = 0; i < 6; i++) begin
            tick(1);
            chk_pin("clock_out_pin toggle", {15'h0000, ~prev}, {15'h0000, drv[0]});
            prev = drv[0];
        end
        rd_chk("status clock_out_pin", p3rcm_pkg::OFS_STATUS, 32'h00000011);
        set_in(1'b0, 1'b0, p3rcm_pkg::CLKSRC_INT_RC, 1'b1);
        tick(2);
        chk_pin("clock_out_pin blocked", 16'h0000, {15'h0000, oe[0]});
        set_in(1'b0, 1'b0, p3rcm_pkg::CLKSRC_INT_RC, 1'b0);
        tick(2);
        wr(p3rcm_pkg::OFS_OSC_TRIM, 32'h00000000);
        tick(1);
        prev = drv[0];
        tick(4);
        chk_pin("clock_out_pin static", {15'h0000, prev}, {15'h0000, drv[0]});
        board_u.drive_port3(2'h3, 2'h0);
        board_u.set_reset(1'b0);
        tick(4);
        chk_pin("no pin reset", 16'h0000, {15'h0000, dev_rst});
        rd_chk("pin low level", p3rcm_pkg::OFS_PIN_LEVEL, 32'h00000000);
        board_u.set_reset(1'b1);
        wr(p3rcm_pkg::OFS_PORT3_MODE, 32'h00000005);
        tick(2);
        chk_pin("pp before reset", 16'h0003, {14'h0000, oe});
        set_in(1'b0, 1'b1, p3rcm_pkg::CLKSRC_INT_RC, 1'b0);
        board_u.set_reset(1'b0);
        tick(4);
        chk_pin("pin reset", 16'h0001, {15'h0000, dev_rst});
        chk_pin("vector", p3rcm_pkg::RESET_VECTOR, vec);
        tick(1);
        chk_pin("oe after pin reset", 16'h0000, {14'h0000, oe});
        board_u.set_reset(1'b1);
        tick(4);
        chk_pin("reset released", 16'h0000, {15'h0000, dev_rst});
        rd_chk("mode after pin reset", p3rcm_pkg::OFS_PORT3_MODE, 32'h0000000A);
        set_in(1'b0, 1'b0, p3rcm_pkg::CLKSRC_INT_RC, 1'b0);
        close_out();
    end
endmodule

// ===== logic/p3rcm_clkdiv.sv
// Divide-by-two generator for the clock output pin.
// Assumes enable comes from logic on the same clock; output is a flop.
module p3rcm_clkdiv (
    input wire logic clock_in,   // CPU clock
    input wire logic rst_in,     // Synchronous reset, high
    input wire logic enable_in,  // Run the divider
    output logic clk_div_out     // Half-rate square wave
);
    typedef struct packed {
        logic level;
    } p3rcm_div_s;

    p3rcm_div_s state;
    p3rcm_div_s next_state;

    always_comb begin
        next_state = state;
        if (enable_in) begin
            next_state.level = ~state.level;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign clk_div_out = state.level;

    chk_div_toggle: assert property (@(posedge clock_in) disable iff (rst_in)
        enable_in |=> clk_div_out != $past(clk_div_out))
        else $error("Clock output did not toggle while enabled.");
    chk_div_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        !enable_in |=> $stable(clk_div_out))
        else $error("Clock output moved while disabled.");
endmodule

// ===== logic/p3rcm_mux.sv
// Pin-function selection for port 1 bit 5 (reset pin) and the two-bit port 3.
// Assumes flash configuration inputs are steady and on this clock; pins are asynchronous.
// Software reaches the mode, latch, trim and status registers over AHB-Lite.
//
// Chosen here: the AHB-Lite register port and the register addresses.

// Function
// - Port 1 bit 5 is an input only and has no output driver at all.
// - The reset pin acts as reset during power-on, otherwise only when the user configuration enables it.
// - A low on the reset pin while it acts as reset resets the device and returns ports to defaults.
// - After a pin reset the processor fetches its first instruction from address zero.
// - Low pulses on the reset pin during power-on are recognised and enter programming mode.
// - Port 3 is a two-bit bidirectional port whose output type software selects.
// - From the cycle after reset begins, the port 3 pins are input only with their pull-ups off.
// - Each port 3 pin has its own mode setting, independent of the other.
// - With the clock output enable bit of the trim register set, port 3 bit 0 drives the CPU clock divided by two.
// - The clock output works only on the RC, watchdog or external clock and never while crystals clock the timer.
// - With a crystal option selected, port 3 bit 0 is the oscillator amplifier output.
// - Port 3 bit 1 is a port pin only on RC or watchdog clock without timer crystal, else the oscillator input.
module p3rcm_mux (
    input wire logic clock_in,              // CPU clock, 25 MHz
    input wire logic rst_in,                // Synchronous reset, high
    input wire logic power_on_in,           // Power-on sequence in progress
    input wire logic user_config_byte1_in,  // Reset pin function enabled by configuration
    input wire logic [1:0] clk_src_in,      // CPU clock source code
    input wire logic rtc_xtal_in,           // Crystal pins clock the timer
    input wire logic port1_bit5_in,         // Reset pin level
    input wire logic [1:0] port3_in,        // Port 3 pin levels
    output logic [1:0] port3_out,           // Port 3 drive levels
    output logic [1:0] port3_oe_out,        // Port 3 output enables
    output logic [1:0] port3_pullup_out,    // Port 3 pull-up enables
    output logic osc_output_sel_out,        // Bit 0 given to oscillator amplifier
    output logic osc_input_sel_out,         // Bit 1 given to oscillator input
    output logic port1_bit5_out,            // Synchronised pin level to the core
    output logic device_reset_out,          // Whole-device reset, high
    output logic [15:0] reset_vector_out,   // First fetch address
    output logic in_system_prog_mode_out,   // Programming mode entered
    input wire logic hsel,                  // AHB select
    input wire logic [31:0] haddr,          // AHB address
    input wire logic [1:0] htrans,          // AHB transfer type
    input wire logic hwrite,                // AHB write
    input wire logic [2:0] hsize,           // AHB size
    input wire logic hready,                // AHB ready in
    input wire logic [31:0] hwdata,         // AHB write data
    output logic [31:0] hrdata,             // AHB read data
    output logic hreadyout,                 // AHB ready out
    output logic hresp                      // AHB response
);
    typedef enum logic [2:0] {
        ISP_WAIT = 3'h1,
        ISP_LOW = 3'h2,
        ISP_DONE = 3'h4
    } p3rcm_isp_e;

    typedef struct packed {
        logic p15_meta;
        logic p15_sync;
        logic [1:0] p3_meta;
        logic [1:0] p3_sync;
        logic [3:0] mode;
        logic [1:0] latch;
        logic [7:0] trim;
        logic [1:0] drv;
        logic [1:0] oe;
        logic [1:0] pull;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        p3rcm_isp_e isp_st;
        logic [1:0] isp_cnt;
    } p3rcm_state_s;

    p3rcm_state_s state;
    p3rcm_state_s next_state;
    logic reset_fn_active;
    logic pin_reset;
    logic dev_reset;
    logic bit0_osc;
    logic bit1_osc;
    logic clock_out_pin_ok;
    logic clock_out_pin_active;
    logic clk_div;
    logic addr_phase;
    logic [7:0] addr_lo;
    logic [31:0] status_word;

    // reset function during power-on or when configured
    assign reset_fn_active = power_on_in | user_config_byte1_in;
    // low on the active reset pin resets the device
    assign pin_reset = reset_fn_active & ~state.p15_sync;
    assign dev_reset = rst_in | pin_reset;

    // crystal option takes bit 0 for the amplifier
    assign bit0_osc = (clk_src_in == p3rcm_pkg::CLKSRC_CRYSTAL) | rtc_xtal_in;
    // bit 1 is a port pin only on RC or watchdog without timer crystal
    assign bit1_osc = ~(((clk_src_in == p3rcm_pkg::CLKSRC_INT_RC) | (clk_src_in == p3rcm_pkg::CLKSRC_WATCHDOG))
        & ~rtc_xtal_in);
    // clock output only on non-crystal sources and no timer crystal
    assign clock_out_pin_ok = (clk_src_in != p3rcm_pkg::CLKSRC_CRYSTAL) & ~rtc_xtal_in;
    assign clock_out_pin_active = state.trim[p3rcm_pkg::TRIM_CLOCK_OUT_PIN_EN_BIT] & clock_out_pin_ok & ~dev_reset;

    assign addr_phase = hsel & hready & (htrans == p3rcm_pkg::HTRANS_NONSEQ);
    assign addr_lo = haddr[7:0];

    assign status_word = {27'h0000000, clock_out_pin_active, bit1_osc, bit0_osc, reset_fn_active,
        state.isp_st == ISP_DONE};

    p3rcm_clkdiv u_clkdiv (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(clock_out_pin_active),
        .clk_div_out(clk_div)
    );

    always_comb begin
        logic [31:0] rd;
        logic [1:0] mode_b;
        rd = 32'h00000000;
        mode_b = 2'h0;
        next_state = state;

        // Pin synchronisers; the first stage feeds only the second.
        next_state.p15_meta = port1_bit5_in;
        next_state.p15_sync = state.p15_meta;
        next_state.p3_meta = port3_in;
        next_state.p3_sync = state.p3_meta;

        // Data phase of a write: store the word that the master now drives.
        next_state.wr_pend = 1'b0;
        if (state.wr_pend) begin
            unique case (state.wr_addr)
                p3rcm_pkg::OFS_PORT3_MODE: next_state.mode = hwdata[3:0];
                p3rcm_pkg::OFS_PORT3_LATCH: next_state.latch = hwdata[1:0];
                // trim register holds the clock output enable
                p3rcm_pkg::OFS_OSC_TRIM: next_state.trim = hwdata[7:0];
                default: next_state.wr_pend = 1'b0;
            endcase
        end

        // Address phase: capture read data now so that it stands in the data phase.
        // A read right behind a write to the same word sees the new value.
        if (addr_phase) begin
            unique case (addr_lo)
                p3rcm_pkg::OFS_PORT3_MODE: rd = {28'h0000000, next_state.mode};
                p3rcm_pkg::OFS_PORT3_LATCH: rd = {30'h00000000, next_state.latch};
                // bit 5 is only ever read, never driven
                p3rcm_pkg::OFS_PIN_LEVEL: rd = {29'h00000000, state.p15_sync, state.p3_sync};
                p3rcm_pkg::OFS_OSC_TRIM: rd = {24'h000000, next_state.trim};
                p3rcm_pkg::OFS_STATUS: rd = status_word;
                default: rd = 32'h00000000;
            endcase
            next_state.rdata = rd;
            next_state.wr_pend = hwrite & (hsize == p3rcm_pkg::HSIZE_WORD);
            next_state.wr_addr = addr_lo;
        end

        // Pin drive per bit; bit 0 and bit 1 special functions override later.
        for (int i = 0; i < 2; i++) begin
            mode_b = next_state.mode[2*i +: 2];
            unique case (mode_b)
                p3rcm_pkg::MODE_QUASI: begin
                    next_state.drv[i] = 1'b0;
                    next_state.oe[i] = ~next_state.latch[i];
                    next_state.pull[i] = 1'b1;
                end
                p3rcm_pkg::MODE_PUSH_PULL: begin
                    next_state.drv[i] = next_state.latch[i];
                    next_state.oe[i] = 1'b1;
                    next_state.pull[i] = 1'b0;
                end
                p3rcm_pkg::MODE_INPUT_ONLY: begin
                    next_state.drv[i] = 1'b0;
                    next_state.oe[i] = 1'b0;
                    next_state.pull[i] = 1'b0;
                end
                p3rcm_pkg::MODE_OPEN_DRAIN: begin
                    next_state.drv[i] = 1'b0;
                    next_state.oe[i] = ~next_state.latch[i];
                    next_state.pull[i] = 1'b0;
                end
            endcase
        end
        if (bit0_osc) begin
            next_state.oe[0] = 1'b0;
            next_state.pull[0] = 1'b0;
        end
        if (bit1_osc) begin
            next_state.oe[1] = 1'b0;
            next_state.pull[1] = 1'b0;
        end

        // count low pulses on the reset pin during power-on
        unique case (state.isp_st)
            ISP_WAIT: begin
                if (power_on_in & ~state.p15_sync) begin
                    next_state.isp_st = ISP_LOW;
                end
            end
            ISP_LOW: begin
                if (state.p15_sync) begin
                    next_state.isp_cnt = state.isp_cnt + 2'h1;
                    next_state.isp_st = (state.isp_cnt + 2'h1 == p3rcm_pkg::ISP_PULSES) ? ISP_DONE : ISP_WAIT;
                end
            end
            ISP_DONE: next_state.isp_st = ISP_DONE;
            default: next_state.isp_st = ISP_WAIT;
        endcase
        if (!power_on_in && state.isp_st != ISP_DONE) begin
            next_state.isp_st = ISP_WAIT;
            next_state.isp_cnt = 2'h0;
        end

        // device reset returns the port and its settings to defaults
        // input only with pull-ups off while in reset
        if (dev_reset) begin
            next_state.mode = p3rcm_pkg::PORT3_MODE_RESET;
            next_state.latch = p3rcm_pkg::PORT3_LATCH_RESET;
            next_state.trim = p3rcm_pkg::OSC_TRIM_RESET;
            next_state.drv = 2'h0;
            next_state.oe = 2'h0;
            next_state.pull = 2'h0;
        end
    end

    // The programming-mode detector and synchronisers survive a pin reset, since the
    // pulses that request the mode are themselves pin resets.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= '{
                p15_meta: 1'b1,
                p15_sync: 1'b1,
                p3_meta: 2'h0,
                p3_sync: 2'h0,
                mode: p3rcm_pkg::PORT3_MODE_RESET,
                latch: p3rcm_pkg::PORT3_LATCH_RESET,
                trim: p3rcm_pkg::OSC_TRIM_RESET,
                drv: 2'h0,
                oe: 2'h0,
                pull: 2'h0,
                wr_pend: 1'b0,
                wr_addr: 8'h00,
                rdata: 32'h00000000,
                isp_st: ISP_WAIT,
                isp_cnt: 2'h0
            };
        end else begin
            state <= next_state;
        end
    end

    // half-rate clock on bit 0 when enabled
    assign port3_out = {state.drv[1], clock_out_pin_active ? clk_div : state.drv[0]};
    assign port3_oe_out = {state.oe[1], state.oe[0] | clock_out_pin_active};
    assign port3_pullup_out = clock_out_pin_active ? {state.pull[1], 1'b0} : state.pull;
    assign osc_output_sel_out = bit0_osc;
    assign osc_input_sel_out = bit1_osc;
    assign port1_bit5_out = state.p15_sync;
    assign device_reset_out = dev_reset;
    assign reset_vector_out = p3rcm_pkg::RESET_VECTOR;
    assign in_system_prog_mode_out = state.isp_st == ISP_DONE;
    assign hrdata = state.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    sequence s_pin_low_active;
        reset_fn_active && !port1_bit5_out;
    endsequence

    sequence s_isp_pulse;
        power_on_in && !port1_bit5_out ##1 power_on_in && port1_bit5_out;
    endsequence

    chk_pin_reset_out: assert property (@(posedge clock_in) disable iff (rst_in)
        s_pin_low_active |-> device_reset_out)
        else $error("Active reset pin low without device reset.");
    chk_pin_reset_gate: assert property (@(posedge clock_in) disable iff (rst_in)
        !reset_fn_active |-> device_reset_out == 1'b0)
        else $error("Reset pin acted while its function was off.");
    chk_reset_inputs: assert property (@(posedge clock_in) disable iff (rst_in)
        device_reset_out |=> port3_oe_out == 2'h0 && port3_pullup_out == 2'h0)
        else $error("Port 3 not input only after reset.");
    chk_reset_vector: assert property (@(posedge clock_in) disable iff (rst_in)
        device_reset_out |-> reset_vector_out == 16'h0000)
        else $error("Reset vector is not zero.");
    chk_clock_out_pin_drive: assert property (@(posedge clock_in) disable iff (rst_in)
        clock_out_pin_active |-> port3_oe_out[0] && port3_out[0] == clk_div)
        else $error("Clock output not on port 3 bit 0.");
    chk_clock_out_pin_source: assert property (@(posedge clock_in) disable iff (rst_in)
        (rtc_xtal_in || clk_src_in == p3rcm_pkg::CLKSRC_CRYSTAL) |-> !clock_out_pin_active)
        else $error("Clock output ran on a crystal source.");
    chk_osc_bit0: assert property (@(posedge clock_in) disable iff (rst_in)
        bit0_osc && $past(bit0_osc) |-> !port3_oe_out[0])
        else $error("Port 3 bit 0 driven while the amplifier owns it.");
    chk_osc_bit1: assert property (@(posedge clock_in) disable iff (rst_in)
        bit1_osc && $past(bit1_osc) |-> osc_input_sel_out && !port3_oe_out[1])
        else $error("Port 3 bit 1 driven while the oscillator owns it.");
    chk_push_pull: assert property (@(posedge clock_in) disable iff (rst_in)
        !dev_reset && state.mode[3:2] == p3rcm_pkg::MODE_PUSH_PULL && !bit1_osc && $stable(state.mode)
        |=> port3_oe_out[1] || $changed(state.mode) || dev_reset || bit1_osc)
        else $error("Port 3 bit 1 push-pull not driving.");
    // Pulses may be many cycles long, so the last one is found by the count already seen.
    chk_isp_entry: assert property (@(posedge clock_in) disable iff (rst_in)
        (state.isp_cnt == p3rcm_pkg::ISP_PULSES - 2'h1) ##0 s_isp_pulse |-> ##[0:2] in_system_prog_mode_out)
        else $error("Programming mode not entered after power-on pulses.");
endmodule

// ===== logic/p3rcm_pkg.sv
// Constants for the port 3, reset pin and clock output multiplexer.
// Assumes a 32-bit AHB-Lite slave on one 25 MHz clock; offsets are byte addresses.
package p3rcm_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_BITS = 8;

    // Register byte offsets.
    localparam logic [7:0] OFS_PORT3_MODE = 8'h00;
    localparam logic [7:0] OFS_PORT3_LATCH = 8'h04;
    localparam logic [7:0] OFS_PIN_LEVEL = 8'h08;
    localparam logic [7:0] OFS_OSC_TRIM = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Port 3 mode codes, two bits per pin.
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
    localparam logic [1:0] MODE_INPUT_ONLY = 2'h2;
    localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;
    localparam logic [3:0] PORT3_MODE_RESET = 4'hA;
    localparam logic [1:0] PORT3_LATCH_RESET = 2'h3;
    localparam logic [7:0] OSC_TRIM_RESET = 8'h00;

    // Field positions.
    localparam int TRIM_CLOCK_OUT_PIN_EN_BIT = 6;
    localparam int LEVEL_P1B5_BIT = 2;
    localparam int STAT_ISP_BIT = 0;
    localparam int STAT_RSTFN_BIT = 1;
    localparam int STAT_OSCOUT_BIT = 2;
    localparam int STAT_OSCIN_BIT = 3;
    localparam int STAT_CLOCK_OUT_PIN_BIT = 4;

    // CPU clock source codes from the flash configuration.
    localparam logic [1:0] CLKSRC_INT_RC = 2'h0;
    localparam logic [1:0] CLKSRC_WATCHDOG = 2'h1;
    localparam logic [1:0] CLKSRC_EXT_CLOCK = 2'h2;
    localparam logic [1:0] CLKSRC_CRYSTAL = 2'h3;

    // Instruction fetch address after reset.
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // Low pulses on the reset pin during power-on that request programming mode.
    localparam logic [1:0] ISP_PULSES = 2'h3;

    // AHB codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
